// [tb/rf_model.sv]
// Purpose: Register file feeding old target values
// Assumes: One write per cycle from the unit
// Notes: Read is combinational
`timescale 1ns/10ps
module rf_model (
  // Clock
  input wire logic clk_i,
  // Read port
  input wire logic [4:0] rd_idx_i,
  output logic [63:0] rd_dat_o,
  // Write port
  input wire logic wr_i,
  input wire logic [4:0] wr_idx_i,
  input wire logic [63:0] wr_dat_i
);
  logic [63:0] mem [32];
  initial begin
    for (int k = 0; k < 32; k++) begin
      mem[k] = {2{32'(32'h9E37_79B9 * k)}};
    end
  end
  always @(posedge clk_i) begin
    if (wr_i) begin
      mem[wr_idx_i] <= wr_dat_i;
    end
  end
  assign rd_dat_o = mem[rd_idx_i];
endmodule

// [tb/rmu_asserts.sv]
// Purpose: Port checks of rotate-mask unit
// Assumes: Config seen via bus writes
// Notes: Bound to top module
`timescale 1ns/10ps
module rmu_asserts (
  // Clock, reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Issue, bus
  input wire logic issue_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic [63:0] target_reg_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Result
  input wire logic result_valid_o,
  input wire logic [63:0] result_o,
  input wire logic [4:0] target_reg_idx_o,
  input wire logic target_wr_o,
  input wire logic condition_field_zero_wr_o,
  input wire logic [3:0] condition_field_zero_o,
  input wire logic illegal_o
);
  // ****
  // Tracked config
  // ****
  logic m64_r, m64_nxt, leg_r, leg_nxt, dw, wd, ok, rec;
  logic [5:0] fb;
  logic [4:0] ix;
  logic [31:0] tu;
  assign dw = issue_valid_i && instr_i[31:26] == 6'h1E && instr_i[4:2] <= 3'h3;
  assign wd = issue_valid_i && instr_i[31:26] == 6'h16;
  assign ok = (dw && m64_r) || (wd && leg_r);
  assign rec = instr_i[0];
  assign fb = instr_i[10:5];
  assign ix = instr_i[20:16];
  assign tu = target_reg_i[63:32];
  always_comb begin
    m64_nxt = m64_r;
    leg_nxt = leg_r;
    if (wb_we_i && wb_ack_o && wb_adr_i[7:2] == 6'h00 && wb_sel_i[0]) begin
      m64_nxt = wb_dat_i[0];
      leg_nxt = wb_dat_i[1];
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      m64_r <= 1'h1;
      leg_r <= 1'h0;
    end else begin
      m64_r <= m64_nxt;
      leg_r <= leg_nxt;
    end
  end
  // ****
  // Properties
  // ****
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_dword_gate:
    assert property (dw && !m64_r |=> illegal_o && !result_valid_o) else $error("dword kept");
  a_word_gate:
    assert property (wd && !leg_r |=> illegal_o && !target_wr_o) else $error("word kept");
  a_word_taken:
    assert property (wd && leg_r |=> target_wr_o && !illegal_o) else $error("word lost");
  a_record_bit:
    assert property (ok |=> condition_field_zero_wr_o == $past(rec)) else $error("record");
  a_field_hold:
    assert property (!condition_field_zero_wr_o && !$past(rst_i)
      |-> $stable(condition_field_zero_o)) else $error("field moved");
  a_left_clear:
    assert property (dw && m64_r && instr_i[4:2] == 3'h0
      |=> (result_o >> (7'h40 - $past(fb))) == 64'h0) else $error("left mask");
  a_right_clear:
    assert property (dw && m64_r && instr_i[4:2] == 3'h1
      |=> (result_o << ($past(fb) + 7'h1)) == 64'h0) else $error("right mask");
  a_word_upper:
    assert property (wd && leg_r |=> result_o[63:32] == $past(tu)) else $error("upper");
  a_bad_sub:
    assert property (issue_valid_i && instr_i[31:26] == 6'h1E && instr_i[4:2] > 3'h3
      |=> !result_valid_o && !illegal_o) else $error("sub taken");
  a_dest_index:
    assert property (ok |=> target_wr_o && target_reg_idx_o == $past(ix)) else $error("idx");
  c_record: cover property (ok && rec);
  c_word: cover property (wd && leg_r);
  c_refused: cover property (illegal_o);
endmodule

bind rotate_mask_unit rmu_asserts chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .issue_valid_i(issue_valid_i), .instr_i(instr_i), .target_reg_i(target_reg_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o), .result_valid_o(result_valid_o), .result_o(result_o),
  .target_reg_idx_o(target_reg_idx_o), .target_wr_o(target_wr_o),
  .condition_field_zero_wr_o(condition_field_zero_wr_o),
  .condition_field_zero_o(condition_field_zero_o), .illegal_o(illegal_o));

// [tb/tb.sv]
// Purpose: Self-checking bench of rotate-mask unit
// Assumes: Partner register file feeds old target
// Notes: Random ops from fixed seed
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0, rst = 1'b1, iv = 1'b0, sov = 1'b0, cyc = 1'b0, we = 1'b0;
  logic [31:0] ins = 32'h0, dat = 32'h0, seed = 32'hEFE8, q, r, rdat;
  logic [63:0] src = 64'h0, cnt = 64'h0, tgt, res, xr [32];
  logic [7:0] adr = 8'h0;
  logic [75:0] p = '0, e = '0;
  logic rv, twr, fwr, ill, ack, m64 = 1'b1, leg = 1'b0;
  logic [4:0] idx;
  logic [3:0] fld;
  logic [3:0] lf = 4'h0;
  int failures = 0, n_checks = 0, nd = 0, ni = 0;
  always #4 clk = ~clk;
  rotate_mask_unit dut_u (.clk_i(clk), .rst_i(rst), .issue_valid_i(iv), .instr_i(ins),
    .source_reg_i(src), .target_reg_i(tgt), .count_reg_i(cnt), .summary_ovf_i(sov),
    .result_valid_o(rv), .result_o(res), .target_reg_idx_o(idx), .target_wr_o(twr),
    .condition_field_zero_wr_o(fwr), .condition_field_zero_o(fld), .illegal_o(ill),
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack));
  rf_model rf_u (.clk_i(clk), .rd_idx_i(ins[20:16]), .rd_dat_o(tgt), .wr_i(twr),
    .wr_idx_i(idx), .wr_dat_i(res));
  // ****
  // Helpers
  // ****
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction
  function automatic logic [63:0] mk(input int b, input int f, input int n);
    mk = '0;
    for (int k = 0; k < n; k++) begin
      if (b <= f ? (k >= b && k <= f) : (k >= b || k <= f)) mk[n-1-k] = 1'b1;
    end
  endfunction
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] x);
    n_checks++;
    if (seen !== x) begin
      failures++;
      $display("unexpected %s exp %h seen %h", nm, x, seen);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] v);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    v = rdat;
    cyc <= 1'b0;
    if (w && a == 8'h00) {leg, m64} = d[1:0];
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] v;
    wb(1'b0, a, 32'h0, v);
    chk("bus read", v, x);
  endtask
  task automatic op(input logic [31:0] i);
    logic [63:0] t, m, x, s, c, fv;
    logic [31:0] w;
    logic [5:0] a, b;
    logic dw, wd, lg, il;
    s = {rnd(), rnd()};
    c = {rnd(), rnd()};
    t = xr[i[20:16]];
    a = {i[1], i[15:11]};
    b = i[10:5];
    dw = i[31:26] == 6'h1E && i[4:2] <= 3'h3;
    wd = i[31:26] == 6'h16;
    case (i[4:2])
      3'h0: m = mk(b, 63, 64);
      3'h1: m = mk(0, b, 64);
      default: m = mk(b, 63 - a, 64);
    endcase
    x = ((s << a) | (s >> (7'h40 - a))) & m;
    if (i[4:2] == 3'h3) x = x | (t & ~m);
    if (wd) begin
      m = mk(i[10:6], i[5:1], 32);
      w = (s[31:0] << c[4:0]) | (s[31:0] >> (6'h20 - c[4:0]));
      x = {t[63:32], (w & m[31:0]) | (t[31:0] & ~m[31:0])};
    end
    lg = (dw && m64) || (wd && leg);
    il = (dw || wd) && !lg;
    fv = m64 ? x : {{32{x[31]}}, x[31:0]};
    if (lg) xr[i[20:16]] = x;
    if (lg && i[0]) lf = {fv[63], !fv[63] && fv != 0, fv == 0, s[0]};
    nd += lg;
    ni += il;
    @(posedge clk);
    iv <= 1'b1;
    ins <= i;
    src <= s;
    cnt <= c;
    sov <= s[0];
    p <= {lg, il, lg && i[0], fv[63], !fv[63] && fv != 0, fv == 0, s[0], i[20:16], x};
  endtask
  task automatic idle();
    @(posedge clk);
    iv <= 1'b0;
    p <= '0;
  endtask
  task conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ****
  // Result monitor
  // ****
  always @(posedge clk) e <= p;
  always @(negedge clk) begin
    if (!rst) begin
      chk("done", rv, e[75]);
      chk("write", twr, e[75]);
      chk("refused", ill, e[74]);
      chk("record", fwr, e[73]);
      if (e[75]) chk("result", res, e[63:0]);
      if (e[75]) chk("index", idx, e[68:64]);
      if (e[73]) chk("field", fld, e[72:69]);
    end
  end
  // ****
  // Tests
  // ****
  initial begin
    repeat (4000) @(posedge clk);
    failures++;
    conclude();
  end
  initial begin
    for (int k = 0; k < 32; k++) xr[k] = {2{32'(32'h9E37_79B9 * k)}};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(8'h00, 32'h1);
    rd(8'h04, 32'h0);
    wb(1'b1, 8'h0C, 32'hFFFF_FFFF, q);
    rd(8'h0C, 32'h0);
    rd(8'h08, 32'h0);
    $display("test reset done");
    for (int ph = 0; ph < 3; ph++) begin
      wb(1'b1, 8'h00, ph == 0 ? 32'h1 : ph == 1 ? 32'h3 : 32'h2, q);
      for (int k = 0; k < 96; k++) begin
        r = rnd();
        if (k < 4) {r[15:11], r[1], r[10:5]} = {{6{k[0]}}, {6{k[1]}}};
        r[31:26] = r[31:28] == 4'hF ? r[27:22] : r[2:0] == 3'h7 ? 6'h16 : 6'h1E;
        op({r[31:21], k[4:0], r[15:0]});
        if (r[20]) idle();
      end
      idle();
      $display("test phase %0d done", ph);
    end
    rd(8'h08, {28'h0, lf});
    rd(8'h04, {ni[15:0], nd[15:0]});
    wb(1'b1, 8'h04, 32'h0, q);
    rd(8'h04, 32'h0);
    $display("test stats done");
    conclude();
  end
endmodule

// [verilog/mask_gen.sv]
// Purpose: Builds a wrapping bit mask from a begin and an end bit number
// Assumes: Bit 0 is the most significant bit
// Notes: Combinational
`timescale 1ns/10ps

module mask_gen (
  // Mask bounds
  input wire logic [5:0] begin_i,
  input wire logic [5:0] end_i,
  // Mask
  output logic [63:0] mask_o
);

  logic wrap;

  assign wrap = (begin_i > end_i);

  // ****************************************
  // One term per bit
  // ****************************************
  for (genvar i = 0; i < 64; i++) begin : g_bit
    localparam logic [5:0] IDX = 6'(i);
    // Ones from begin to end, wrapping when begin passes end
    assign mask_o[63 - i] = wrap ? ((IDX >= begin_i) || (IDX <= end_i))
                                 : ((IDX >= begin_i) && (IDX <= end_i));
  end

endmodule

// [verilog/rmu_map.svh]
// Purpose: Encodings, field positions, offsets and reset values of the rotate-mask unit
// Assumes: Big-endian bit numbering in the instruction word maps bit n to index 31-n
// Notes: Definitions only
`ifndef RMU_MAP_SVH
`define RMU_MAP_SVH

// ****************************************
// Instruction fields
// ****************************************
`define RMU_OPC_MSB 31
`define RMU_OPC_LSB 26
`define RMU_SRC_MSB 25
`define RMU_SRC_LSB 21
`define RMU_TGT_MSB 20
`define RMU_TGT_LSB 16
`define RMU_SH_MSB 15
`define RMU_SH_LSB 11
`define RMU_MB6_MSB 10
`define RMU_MB6_LSB 5
`define RMU_SUB_MSB 4
`define RMU_SUB_LSB 2
`define RMU_SH5_BIT 1
`define RMU_MB5_MSB 10
`define RMU_MB5_LSB 6
`define RMU_ME5_MSB 5
`define RMU_ME5_LSB 1
`define RMU_REC_BIT 0
`define RMU_CNT_MSB 4
`define RMU_CNT_LSB 0

// ****************************************
// Opcodes
// ****************************************
`define RMU_OPC_DWORD 6'h1E
`define RMU_OPC_WORD 6'h16
`define RMU_SUB_LEFT 3'h0
`define RMU_SUB_RIGHT 3'h1
`define RMU_SUB_BOTH 3'h2
`define RMU_SUB_INSERT 3'h3

// ****************************************
// Constants
// ****************************************
`define RMU_BIT_FIRST 6'h00
`define RMU_BIT_LAST 6'h3F
`define RMU_LOW_WORD_MASK 64'h0000_0000_FFFF_FFFF
`define RMU_ALL_ONES 64'hFFFF_FFFF_FFFF_FFFF
`define RMU_DWORD_ZERO 64'h0000_0000_0000_0000
`define RMU_WORD_HALF 1'h1

// ****************************************
// Register map and reset values
// ****************************************
`define RMU_ADR_CFG 6'h00
`define RMU_ADR_STAT 6'h01
`define RMU_ADR_LAST 6'h02
`define RMU_CFG_MODE64_BIT 0
`define RMU_CFG_LEGACY_BIT 1
`define RMU_CFG_MODE64_RST 1'h1
`define RMU_CFG_LEGACY_RST 1'h0
`define RMU_CNT_ONE 16'h0001
`define RMU_CNT_ZERO 16'h0000
`define RMU_WORD_ZERO 32'h0000_0000

`endif

// [verilog/rmu_pkg.sv]
// Purpose: Types shared by the rotate-mask unit
// Assumes: Nothing
// Notes: Encodings of operations
package rmu_pkg;

  typedef enum logic [2:0] {
    OP_CLEAR_LEFT  = 3'b000,
    OP_CLEAR_RIGHT = 3'b001,
    OP_CLEAR_BOTH  = 3'b010,
    OP_INSERT      = 3'b011,
    OP_WORD_INSERT = 3'b100,
    OP_NONE        = 3'b111
  } op_t;

  typedef logic [63:0] dword_t;
  typedef logic [3:0] cr_field_t;

endpackage

// [verilog/rotate_mask_unit.sv]
// Purpose: Rotate-and-mask execution unit with a Wishbone control slave
// Assumes: Operand values come from the register file on the same clock
// Notes: Result one cycle after issue; all outputs registered
`include "rmu_map.svh"
`timescale 1ns/10ps

// Contract
// - Clear-both rotates, masks begin through 63-shift
// - Clear-left rotates, masks begin through 63
// - Clear-right rotates, masks 0 through end
// - Insert merges rotated bits under begin..63-shift mask
// - Record bit set updates condition field zero
// - Doubleword forms illegal on 32-bit implementation
// - Word insert rotates by count register value
// - Word insert exists only in older family
// - Count from bits 27-31, 32-bit word
// - Wrapping mask from begin and end
// - Mask zero keeps target bit, one inserts
module rotate_mask_unit (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Issue from decoder and register file
  input wire logic issue_valid_i,
  input wire logic [31:0] instr_i,
  input wire logic [63:0] source_reg_i,
  input wire logic [63:0] target_reg_i,
  input wire logic [63:0] count_reg_i,
  input wire logic summary_ovf_i,
  // Result to register file
  output logic result_valid_o,
  output logic [63:0] result_o,
  output logic [4:0] target_reg_idx_o,
  output logic target_wr_o,
  output logic condition_field_zero_wr_o,
  output logic [3:0] condition_field_zero_o,
  output logic illegal_o,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  // ****************************************
  // Declarations
  // ****************************************
  logic [5:0] opcode;
  logic [2:0] sub_op;
  rmu_pkg::op_t op;
  logic [5:0] shift_amount;
  logic [5:0] mask_begin;
  logic [5:0] mask_end;
  logic [4:0] word_count;
  logic record_bit;
  logic is_dword;
  logic is_word;
  logic legal;
  logic [127:0] rot_wide;
  logic [63:0] rot_word_wide;
  rmu_pkg::dword_t rot64;
  logic [31:0] rot32;
  logic [5:0] gen_begin;
  logic [5:0] gen_end;
  rmu_pkg::dword_t gen_mask;
  rmu_pkg::dword_t mask;
  rmu_pkg::dword_t data;
  rmu_pkg::dword_t keep;
  rmu_pkg::dword_t result;
  rmu_pkg::dword_t cmp_val;
  logic cmp_lt;
  logic cmp_eq;
  rmu_pkg::cr_field_t cr_val;

  logic result_valid_r;
  logic result_valid_nxt;
  rmu_pkg::dword_t result_r;
  rmu_pkg::dword_t result_nxt;
  logic [4:0] target_idx_r;
  logic [4:0] target_idx_nxt;
  logic target_wr_r;
  logic target_wr_nxt;
  logic cr_wr_r;
  logic cr_wr_nxt;
  rmu_pkg::cr_field_t cr_r;
  rmu_pkg::cr_field_t cr_nxt;
  logic illegal_r;
  logic illegal_nxt;

  logic mode64_r;
  logic mode64_nxt;
  logic legacy_r;
  logic legacy_nxt;
  logic [15:0] done_cnt_r;
  logic [15:0] done_cnt_nxt;
  logic [15:0] illegal_cnt_r;
  logic [15:0] illegal_cnt_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic bus_req;
  logic bus_wr;
  logic [5:0] word_adr;

  // ****************************************
  // Decode
  // ****************************************
  always_comb begin
    opcode = instr_i[`RMU_OPC_MSB:`RMU_OPC_LSB];
    sub_op = instr_i[`RMU_SUB_MSB:`RMU_SUB_LSB];
    record_bit = instr_i[`RMU_REC_BIT];
    // Doubleword forms: opcode 30 and sub-op 0 to 3
    is_dword = (opcode == `RMU_OPC_DWORD) && (sub_op <= `RMU_SUB_INSERT);
    // Word insert form: opcode 22
    is_word = (opcode == `RMU_OPC_WORD);
    op = rmu_pkg::OP_NONE;
    if (is_dword) begin
      unique case (sub_op)
        `RMU_SUB_LEFT: op = rmu_pkg::OP_CLEAR_LEFT;
        `RMU_SUB_RIGHT: op = rmu_pkg::OP_CLEAR_RIGHT;
        `RMU_SUB_BOTH: op = rmu_pkg::OP_CLEAR_BOTH;
        default: op = rmu_pkg::OP_INSERT;
      endcase
    end else if (is_word) begin
      op = rmu_pkg::OP_WORD_INSERT;
    end
    // Six-bit shift from bits 16-20 and bit 30
    shift_amount = {instr_i[`RMU_SH5_BIT], instr_i[`RMU_SH_MSB:`RMU_SH_LSB]};
    mask_begin = instr_i[`RMU_MB6_MSB:`RMU_MB6_LSB];
    mask_end = instr_i[`RMU_MB6_MSB:`RMU_MB6_LSB];
    // Rotate count from bits 27-31 of the count register
    word_count = count_reg_i[`RMU_CNT_MSB:`RMU_CNT_LSB];
    // Doubleword forms need 64-bit mode, word insert the older family
    legal = is_dword ? mode64_r : legacy_r;
  end

  // ****************************************
  // Rotate
  // ****************************************
  always_comb begin
    rot_wide = {source_reg_i, source_reg_i} << shift_amount;
    rot64 = rot_wide[127:64];
    // Word rotation on the low 32 bits
    rot_word_wide = {source_reg_i[31:0], source_reg_i[31:0]} << word_count;
    rot32 = rot_word_wide[63:32];
  end

  // ****************************************
  // Mask bounds
  // ****************************************
  always_comb begin
    gen_begin = mask_begin;
    gen_end = `RMU_BIT_LAST;
    unique case (op)
      rmu_pkg::OP_CLEAR_LEFT: begin
        gen_begin = mask_begin;
        gen_end = `RMU_BIT_LAST;
      end
      rmu_pkg::OP_CLEAR_RIGHT: begin
        gen_begin = `RMU_BIT_FIRST;
        gen_end = mask_end;
      end
      rmu_pkg::OP_CLEAR_BOTH, rmu_pkg::OP_INSERT: begin
        gen_begin = mask_begin;
        gen_end = `RMU_BIT_LAST - shift_amount;
      end
      rmu_pkg::OP_WORD_INSERT: begin
        // Word bounds placed in the low half
        gen_begin = {`RMU_WORD_HALF, instr_i[`RMU_MB5_MSB:`RMU_MB5_LSB]};
        gen_end = {`RMU_WORD_HALF, instr_i[`RMU_ME5_MSB:`RMU_ME5_LSB]};
      end
      rmu_pkg::OP_NONE: begin
        gen_begin = mask_begin;
        gen_end = `RMU_BIT_LAST;
      end
    endcase
  end

  mask_gen u_mask_gen (
    .begin_i(gen_begin),
    .end_i(gen_end),
    .mask_o(gen_mask)
  );

  // ****************************************
  // Merge and condition
  // ****************************************
  always_comb begin
    if (op == rmu_pkg::OP_WORD_INSERT) begin
      mask = gen_mask & `RMU_LOW_WORD_MASK;
      data = {rot32, rot32};
    end else begin
      mask = gen_mask & `RMU_ALL_ONES;
      data = rot64;
    end
    // Insert forms keep target bits where the mask is zero
    if ((op == rmu_pkg::OP_INSERT) || (op == rmu_pkg::OP_WORD_INSERT)) begin
      keep = target_reg_i & ~mask;
    end else begin
      keep = `RMU_DWORD_ZERO;
    end
    result = (data & mask) | keep;
    if (mode64_r) begin
      cmp_val = result;
    end else begin
      cmp_val = {{32{result[31]}}, result[31:0]};
    end
    cmp_lt = cmp_val[63];
    cmp_eq = (cmp_val == `RMU_DWORD_ZERO);
    // Less, greater, equal, summary overflow
    cr_val = {cmp_lt, !cmp_lt && !cmp_eq, cmp_eq, summary_ovf_i};
  end

  // ****************************************
  // Result stage
  // ****************************************
  always_comb begin
    result_valid_nxt = 1'b0;
    target_wr_nxt = 1'b0;
    cr_wr_nxt = 1'b0;
    illegal_nxt = 1'b0;
    result_nxt = result_r;
    target_idx_nxt = target_idx_r;
    cr_nxt = cr_r;
    if (issue_valid_i && (op != rmu_pkg::OP_NONE)) begin
      if (legal) begin
        result_valid_nxt = 1'b1;
        target_wr_nxt = 1'b1;
        result_nxt = result;
        target_idx_nxt = instr_i[`RMU_TGT_MSB:`RMU_TGT_LSB];
        // Field zero written only with record bit set
        cr_wr_nxt = record_bit;
        if (record_bit) begin
          cr_nxt = cr_val;
        end
      end else begin
        // Refused instead of executed
        illegal_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      result_valid_r <= 1'b0;
      result_r <= `RMU_DWORD_ZERO;
      target_idx_r <= 5'h00;
      target_wr_r <= 1'b0;
      cr_wr_r <= 1'b0;
      cr_r <= 4'h0;
      illegal_r <= 1'b0;
    end else begin
      result_valid_r <= result_valid_nxt;
      result_r <= result_nxt;
      target_idx_r <= target_idx_nxt;
      target_wr_r <= target_wr_nxt;
      cr_wr_r <= cr_wr_nxt;
      cr_r <= cr_nxt;
      illegal_r <= illegal_nxt;
    end
  end

  // ****************************************
  // Wishbone registers
  // ****************************************
  always_comb begin
    bus_req = wb_cyc_i && wb_stb_i;
    word_adr = wb_adr_i[7:2];
    bus_wr = bus_req && wb_we_i && ack_r;
    ack_nxt = bus_req && !ack_r;
    mode64_nxt = mode64_r;
    legacy_nxt = legacy_r;
    done_cnt_nxt = done_cnt_r;
    illegal_cnt_nxt = illegal_cnt_r;
    dat_nxt = `RMU_WORD_ZERO;
    if (bus_wr && (word_adr == `RMU_ADR_CFG) && wb_sel_i[0]) begin
      mode64_nxt = wb_dat_i[`RMU_CFG_MODE64_BIT];
      legacy_nxt = wb_dat_i[`RMU_CFG_LEGACY_BIT];
    end
    if (bus_wr && (word_adr == `RMU_ADR_STAT) && (wb_sel_i != 4'h0)) begin
      done_cnt_nxt = `RMU_CNT_ZERO;
      illegal_cnt_nxt = `RMU_CNT_ZERO;
    end
    // Count after clear so a same-cycle event survives
    if (result_valid_nxt) begin
      done_cnt_nxt = done_cnt_nxt + `RMU_CNT_ONE;
    end
    if (illegal_nxt) begin
      illegal_cnt_nxt = illegal_cnt_nxt + `RMU_CNT_ONE;
    end
    if (ack_nxt && !wb_we_i) begin
      unique case (word_adr)
        `RMU_ADR_CFG: dat_nxt = {30'h0, legacy_r, mode64_r};
        `RMU_ADR_STAT: dat_nxt = {illegal_cnt_r, done_cnt_r};
        `RMU_ADR_LAST: dat_nxt = {27'h0, cr_wr_r, cr_r};
        default: dat_nxt = `RMU_WORD_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode64_r <= `RMU_CFG_MODE64_RST;
      legacy_r <= `RMU_CFG_LEGACY_RST;
      done_cnt_r <= `RMU_CNT_ZERO;
      illegal_cnt_r <= `RMU_CNT_ZERO;
      ack_r <= 1'b0;
      dat_r <= `RMU_WORD_ZERO;
    end else begin
      mode64_r <= mode64_nxt;
      legacy_r <= legacy_nxt;
      done_cnt_r <= done_cnt_nxt;
      illegal_cnt_r <= illegal_cnt_nxt;
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign result_valid_o = result_valid_r;
  assign result_o = result_r;
  assign target_reg_idx_o = target_idx_r;
  assign target_wr_o = target_wr_r;
  assign condition_field_zero_wr_o = cr_wr_r;
  assign condition_field_zero_o = cr_r;
  assign illegal_o = illegal_r;
  assign wb_dat_o = dat_r;
  assign wb_ack_o = ack_r;

endmodule
